// ### lbl_engine.sv
// line block link engine: receive framer, transmit framer, apb registers
//
// Overview of operation
// - extract answers and controls from data stream
// - parity, translate, count, store; 80 then terminate
// - idle after data ignored; termination accepted only after the 80th data char
// - check parity char; pass block or fault
// - segment end to non-data; message end ends message
// - send three idles, then flag host ready
// - reject or discard bit sends only that
// - begin char chosen by start and priority
// - route char on first block, else ignore
// - data from buffer, translated, parity after send
// - after 80th, terminate or poll until acknowledged
// - end char from end bit; keep warning
// - parity char next, awaiting flag set
// - parity send sets awaiting, clears good
// - unexpected replies are discarded
// - fault or wrong ack restarts previous block
// - correct ack frees buffer, flags host unless warning kept
// - hold answer only clears awaiting
// - no good ack: poll, forty idles, repeat
// - answer only when solicited; the ack queued on host acceptance is sent without a poll
// - bad block purged; good block acknowledged later
// - poll before acceptance answered with hold
// - begin chars accepted by message state
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "lbl_defs.svh"

module lbl_engine
	import lbl_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        SRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        RX_VALID,
	input  wire logic [7:0]  RX_CHAR,
	input  wire logic        RX_VPAR_ERR,
	input  wire logic        TX_REQ,
	output logic             TX_VALID,
	output logic      [7:0]  TX_CHAR
);

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------

	// reply characters sent by the far end
	function automatic logic is_reply(input logic [7:0] c);
		is_reply = (c == `LBL_POS_ANSWER_ONE) || (c == `LBL_POS_ANSWER_TWO) ||
			(c == `LBL_FAULT_ANSWER) || (c == `LBL_HOLD_ANSWER);
	endfunction : is_reply

	// acknowledgment expected for a given alternation bit
	function automatic logic [7:0] ack_of(input logic sel);
		ack_of = sel ? `LBL_POS_ANSWER_TWO : `LBL_POS_ANSWER_ONE;
	endfunction : ack_of

	// line code translation; identity until a code table is fitted
	function automatic logic [7:0] xlate(input logic [7:0] c);
		xlate = c;
	endfunction : xlate

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------

	lbl_state_t s_r;                 // all registered state
	lbl_state_t s_nxt;               // next state
	logic       apb_acc;             // apb access taken this cycle
	logic [7:0] c1;                  // first control of sending block
	logic [7:0] c2;                  // second control of sending block

	assign apb_acc = PSEL & PENABLE & ~s_r.pready;
	assign c1      = s_r.tx_c1[s_r.cur];
	assign c2      = s_r.tx_c2[s_r.cur];

	// ------------------------------------------------------------
	// next state logic
	// ------------------------------------------------------------

	always_comb begin
		s_nxt          = s_r;
		s_nxt.pready   = 1'b0;
		s_nxt.pslverr  = 1'b0;
		s_nxt.tx_valid = 1'b0;

		// ---- receive side ----
		if (RX_VALID) begin
			if (is_reply(RX_CHAR)) begin
				// replies are pulled out of any position in the stream
				if (s_r.awaiting) begin
					// unexpected replies fall through untouched
					if (RX_CHAR == `LBL_HOLD_ANSWER) begin
						s_nxt.awaiting = 1'b0; // good stays off
					end else if (RX_CHAR == ack_of(s_r.tx_ack_sel)) begin
						// correct ack frees the acknowledged area
						s_nxt.tx_full[s_r.prev] = 1'b0;
						s_nxt.awaiting          = 1'b0;
						s_nxt.good              = 1'b1;
						s_nxt.tx_ack_sel        = ~s_r.tx_ack_sel;
						if (!s_r.warn) begin
							s_nxt.tx_ready = 1'b1;
						end
					end else begin
						// fault or wrong ack: drop current, resend previous
						s_nxt.cur      = s_r.prev;
						s_nxt.tx_st    = TX_IDLE;
						s_nxt.good     = 1'b1;
						s_nxt.awaiting = 1'b0;
					end
				end
			end else if (RX_CHAR == `LBL_RESEND_POLL) begin
				// a poll solicits the last reply; hold until accepted
				s_nxt.ans_pend = 1'b1;
				s_nxt.ans_char = s_r.rx_acc ? s_r.last_reply : `LBL_HOLD_ANSWER;
			end else begin
				case (s_r.rx_st)
					RX_START: begin
						// begin chars valid only per message state
						if (!s_r.msg && (RX_CHAR == `LBL_MSG_BEGIN_LOW ||
							RX_CHAR == `LBL_MSG_BEGIN_HIGH)) begin
							s_nxt.msg   = 1'b1;
							s_nxt.rx_st = RX_SEL;
						end else if (s_r.msg && RX_CHAR == `LBL_SEG_BEGIN_CHAR) begin
							s_nxt.rx_st = RX_SEL;
						end
						s_nxt.rx_par  = 8'h00;
						s_nxt.rx_cnt  = 7'd0;
						s_nxt.rx_verr = 1'b0;
					end
					RX_SEL: begin
						// selection character ahead of the data is passed over, not stored
						s_nxt.rx_st = RX_DATA;
					end
					RX_DATA: begin
						if (RX_CHAR != `LBL_IDLE_CHAR) begin
							// parity, translate, count, store
							s_nxt.rx_par              = s_r.rx_par ^ RX_CHAR;
							s_nxt.rx_buf[s_r.rx_cnt] = xlate(RX_CHAR);
							s_nxt.rx_cnt              = s_r.rx_cnt + 7'd1;
							s_nxt.rx_verr             = s_r.rx_verr | RX_VPAR_ERR;
							if (s_r.rx_cnt == `LBL_LAST_IDX) begin
								s_nxt.rx_st = RX_TERM;
							end
						end
					end
					RX_TERM: begin
						// idles are let pass uncounted
						if (RX_CHAR == `LBL_SEG_END_CHAR || RX_CHAR == `LBL_MSG_END_CHAR) begin
							s_nxt.rx_term_msg = (RX_CHAR == `LBL_MSG_END_CHAR);
							s_nxt.rx_st       = RX_BP;
						end
					end
					RX_BP: begin
						// next char is the block parity
						s_nxt.ans_pend = 1'b1;
						if (RX_CHAR == s_r.rx_par && !s_r.rx_verr && !RX_VPAR_ERR) begin
							s_nxt.rx_avail   = 1'b1;
							s_nxt.rx_acc     = 1'b0;
							s_nxt.rd_idx     = 7'd0;
							s_nxt.ans_char   = `LBL_HOLD_ANSWER;
							s_nxt.last_reply = `LBL_HOLD_ANSWER;
							if (s_r.rx_term_msg) begin
								s_nxt.msg = 1'b0; // only a verified message end closes it
							end
						end else begin
							// purge and wait for the resend; the message stays open for it
							s_nxt.ans_char = `LBL_FAULT_ANSWER;
						end
						s_nxt.rx_st = RX_START; // back to non-data
					end
					default: s_nxt.rx_st = RX_START;
				endcase
			end
		end

		// ---- transmit side, one char per line request ----
		if (TX_REQ) begin
			s_nxt.tx_valid = 1'b1;
			s_nxt.tx_char  = `LBL_IDLE_CHAR;
			if (s_r.ans_pend && s_r.tx_st != TX_FRAME) begin
				// answers slip in between block characters
				s_nxt.tx_char  = s_r.ans_char;
				s_nxt.ans_pend = 1'b0;
			end else begin
				case (s_r.tx_st)
					TX_FRAME: begin
						// idles until framing is set up
						if (s_r.enable) begin
							s_nxt.frame_cnt = s_r.frame_cnt + 2'd1;
							if (s_r.frame_cnt == `LBL_FRAME_IDLES - 2'd1) begin
								s_nxt.framed   = 1'b1;
								s_nxt.tx_ready = 1'b1;
								s_nxt.tx_st    = TX_IDLE;
							end
						end
					end
					TX_IDLE: begin
						if (s_r.tx_full[s_r.cur]) begin
							s_nxt.tx_par = 8'h00;
							s_nxt.tx_idx = 7'd0;
							if (c1[`LBL_C1_REJECT]) begin
								// only the requested signal goes out
								s_nxt.tx_char          = `LBL_REJECT_MESSAGE;
								s_nxt.tx_full[s_r.cur] = 1'b0;
								s_nxt.cur              = ~s_r.cur;
								s_nxt.tx_ready         = 1'b1;
							end else if (c1[`LBL_C1_DISCARD]) begin
								s_nxt.tx_char          = `LBL_DISCARD_MSG;
								s_nxt.tx_full[s_r.cur] = 1'b0;
								s_nxt.cur              = ~s_r.cur;
								s_nxt.tx_ready         = 1'b1;
							end else begin
								// begin char from start and priority bits
								if (!c1[`LBL_C1_START]) begin
									s_nxt.tx_char = `LBL_SEG_BEGIN_CHAR;
								end else if (c1[`LBL_C1_PRIO]) begin
									s_nxt.tx_char = `LBL_MSG_BEGIN_HIGH;
								end else begin
									s_nxt.tx_char = `LBL_MSG_BEGIN_LOW;
								end
								s_nxt.tx_st = TX_SEL;
							end
						end
					end
					TX_SEL: begin
						// route char only on a message's first block
						if (!c1[`LBL_C1_START]) begin
							s_nxt.tx_char = `LBL_IGNORE_CHAR;
						end else if (c1[`LBL_C1_ROUTE]) begin
							s_nxt.tx_char = `LBL_ROUTE_CHAR_ONE;
						end else begin
							s_nxt.tx_char = `LBL_ROUTE_CHAR_ZERO;
						end
						s_nxt.tx_st = TX_DATA;
					end
					TX_DATA: begin
						// translated data, summed once sent
						s_nxt.tx_char = xlate(s_r.tx_buf[s_r.cur][s_r.tx_idx]);
						s_nxt.tx_par  = s_r.tx_par ^ s_nxt.tx_char;
						s_nxt.tx_idx  = s_r.tx_idx + 7'd1;
						if (s_r.tx_idx == `LBL_LAST_IDX) begin
							s_nxt.tx_st = TX_CHK;
						end
					end
					TX_CHK: begin
						if (s_r.good) begin
							// end char by end bit; warning kept
							s_nxt.tx_char = c2[`LBL_C2_END] ? `LBL_MSG_END_CHAR : `LBL_SEG_END_CHAR;
							s_nxt.warn    = c2[`LBL_C2_WARN];
							s_nxt.tx_st   = TX_BP;
						end else begin
							// poll in place of termination
							s_nxt.tx_char  = `LBL_RESEND_POLL;
							s_nxt.awaiting = 1'b1;
							s_nxt.poll_cnt = `LBL_POLL_IDLES;
							s_nxt.tx_st    = TX_POLL;
						end
					end
					TX_POLL: begin
						// forty idles, then look again
						s_nxt.poll_cnt = s_r.poll_cnt - 6'd1;
						if (s_r.poll_cnt == 6'd1) begin
							s_nxt.tx_st = TX_CHK;
						end
					end
					TX_BP: begin
						// parity out solicits a reply
						s_nxt.tx_char  = s_r.tx_par;
						s_nxt.awaiting = 1'b1;
						s_nxt.good     = 1'b0;
						s_nxt.prev     = s_r.cur;
						s_nxt.cur      = ~s_r.cur;
						s_nxt.tx_st    = TX_IDLE;
					end
					default: s_nxt.tx_st = TX_FRAME;
				endcase
			end
		end

		// ---- apb register access ----
		if (apb_acc) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = 32'h00000000;
			case (PADDR)
				`LBL_OFS_CTRL: begin
					if (PWRITE) begin
						s_nxt.enable = PWDATA[0];
					end
					s_nxt.prdata[0] = s_r.enable;
				end
				`LBL_OFS_STATUS: begin
					// live state of both directions
					s_nxt.prdata[7:0] = {s_r.warn, s_r.rx_st != RX_START, s_r.msg,
						s_r.good, s_r.awaiting, s_r.rx_avail, s_r.tx_ready, s_r.framed};
				end
				`LBL_OFS_TX_CTL: begin
					if (PWRITE) begin
						s_nxt.tx_c1[s_r.hw_sel] = PWDATA[7:0];
						s_nxt.tx_c2[s_r.hw_sel] = PWDATA[15:8];
						if (PWDATA[`LBL_TXC_GO]) begin
							// commit: the block becomes sendable
							s_nxt.tx_full[s_r.hw_sel] = 1'b1;
							s_nxt.hw_sel              = ~s_r.hw_sel;
							s_nxt.hw_idx              = 7'd0;
							// a ready set by an ack this cycle wins
							s_nxt.tx_ready = s_nxt.tx_ready & ~s_r.tx_ready;
						end
					end
					s_nxt.prdata[1:0] = s_r.tx_full;
				end
				`LBL_OFS_TX_DATA: begin
					if (PWRITE) begin
						s_nxt.tx_buf[s_r.hw_sel][s_r.hw_idx] = PWDATA[7:0];
						s_nxt.hw_idx = (s_r.hw_idx == `LBL_LAST_IDX) ? 7'd0 : s_r.hw_idx + 7'd1;
					end
				end
				`LBL_OFS_RX_DATA: begin
					// each read steps to the next character
					s_nxt.prdata[7:0] = s_r.rx_buf[s_r.rd_idx];
					if (!PWRITE) begin
						s_nxt.rd_idx = (s_r.rd_idx == `LBL_LAST_IDX) ? 7'd0 : s_r.rd_idx + 7'd1;
					end
				end
				`LBL_OFS_RX_ACC: begin
					if (PWRITE && PWDATA[0] && s_r.rx_avail && !s_nxt.rx_avail == 1'b0) begin
						// host took the block: queue the correct ack
						s_nxt.rx_avail   = 1'b0;
						s_nxt.rx_acc     = 1'b1;
						s_nxt.last_reply = ack_of(s_r.rx_ack_sel);
						s_nxt.ans_pend   = 1'b1;
						s_nxt.ans_char   = ack_of(s_r.rx_ack_sel);
						s_nxt.rx_ack_sel = ~s_r.rx_ack_sel;
					end
					s_nxt.prdata[0] = s_r.rx_acc;
				end
				default: s_nxt.pslverr = 1'b1; // unmapped address
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			s_r            <= '0;
			s_r.rx_st      <= RX_START;
			s_r.tx_st      <= TX_FRAME;
			s_r.good       <= 1'b1;   // first block may terminate
			s_r.rx_acc     <= 1'b1;
			s_r.last_reply <= `LBL_POS_ANSWER_TWO;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs, all straight from flops
	// ------------------------------------------------------------

	assign PRDATA   = s_r.prdata;
	assign PREADY   = s_r.pready;
	assign PSLVERR  = s_r.pslverr;
	assign TX_VALID = s_r.tx_valid;
	assign TX_CHAR  = s_r.tx_char;

endmodule : lbl_engine

// ### lbl_defs.svh
// constants of the line block link engine: codes, offsets, fields, counts
`ifndef LBL_DEFS_SVH
`define LBL_DEFS_SVH
// line codes (plain defaults, set per line code in use)
`define LBL_IDLE_CHAR      8'h16
`define LBL_SEG_END_CHAR   8'h03
`define LBL_MSG_END_CHAR   8'h04
`define LBL_SEG_BEGIN_CHAR 8'h02
`define LBL_MSG_BEGIN_LOW  8'h01
`define LBL_MSG_BEGIN_HIGH 8'h11
`define LBL_RESEND_POLL    8'h05
`define LBL_FAULT_ANSWER   8'h15
`define LBL_HOLD_ANSWER    8'h17
`define LBL_POS_ANSWER_ONE 8'h06
`define LBL_POS_ANSWER_TWO 8'h07
`define LBL_REJECT_MESSAGE 8'h18
`define LBL_DISCARD_MSG    8'h19
`define LBL_ROUTE_CHAR_ZERO 8'h12
`define LBL_ROUTE_CHAR_ONE 8'h13
`define LBL_IGNORE_CHAR    8'h14
// register byte offsets
`define LBL_OFS_CTRL     8'h00
`define LBL_OFS_STATUS   8'h04
`define LBL_OFS_TX_CTL   8'h08
`define LBL_OFS_TX_DATA  8'h0C
`define LBL_OFS_RX_DATA  8'h10
`define LBL_OFS_RX_ACC   8'h14
// first control character bits
`define LBL_C1_REJECT    0
`define LBL_C1_DISCARD   1
`define LBL_C1_START     2
`define LBL_C1_PRIO      3
`define LBL_C1_ROUTE     4
// second control character bits
`define LBL_C2_END       0
`define LBL_C2_WARN      1
// tx control register: commit bit
`define LBL_TXC_GO       16
// counts in characters
`define LBL_BLOCK_LEN    7'd80
`define LBL_LAST_IDX     7'd79
`define LBL_FRAME_IDLES  2'd3
`define LBL_POLL_IDLES   6'd40
`endif

// ### lbl_pkg.sv
// types of the line block link engine
package lbl_pkg;
	typedef enum logic [2:0] {RX_START, RX_SEL, RX_DATA, RX_TERM, RX_BP} lbl_rx_t;
	typedef enum logic [2:0] {TX_FRAME, TX_IDLE, TX_SEL, TX_DATA, TX_CHK, TX_POLL, TX_BP} lbl_tx_t;
	typedef struct packed {
		lbl_rx_t                 rx_st;
		logic                    msg;
		logic                    rx_verr;
		logic                    rx_term_msg;
		logic [6:0]              rx_cnt;
		logic [7:0]              rx_par;
		logic [79:0][7:0]        rx_buf;
		logic                    rx_avail;
		logic                    rx_acc;
		logic                    rx_ack_sel;
		logic [7:0]              last_reply;
		logic                    ans_pend;
		logic [7:0]              ans_char;
		lbl_tx_t                 tx_st;
		logic [1:0]              frame_cnt;
		logic                    framed;
		logic [1:0][79:0][7:0]   tx_buf;
		logic [1:0][7:0]         tx_c1;
		logic [1:0][7:0]         tx_c2;
		logic [1:0]              tx_full;
		logic                    hw_sel;
		logic [6:0]              hw_idx;
		logic                    cur;
		logic                    prev;
		logic [6:0]              tx_idx;
		logic [7:0]              tx_par;
		logic [5:0]              poll_cnt;
		logic                    awaiting;
		logic                    good;
		logic                    warn;
		logic                    tx_ack_sel;
		logic                    tx_ready;
		logic                    tx_valid;
		logic [7:0]              tx_char;
		logic                    enable;
		logic [6:0]              rd_idx;
		logic                    pready;
		logic                    pslverr;
		logic [31:0]             prdata;
	} lbl_state_t;
endpackage : lbl_pkg

// ### lbl_engine_checker.sv
// port assertions of the line block link engine
`timescale 1ns/1ns
`include "lbl_defs.svh"
module lbl_engine_checker (
	input wire logic       CLK_SYS,
	input wire logic       SRST,
	input wire logic       PSEL,
	input wire logic       PENABLE,
	input wire logic [7:0] PADDR,
	input wire logic       PREADY,
	input wire logic       PSLVERR,
	input wire logic       TX_REQ,
	input wire logic       TX_VALID,
	input wire logic [7:0] TX_CHAR
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	// ------------------------------
	// helper logic
	// ------------------------------
	logic [1:0] n_tx_r; // chars sent since reset, stops at three
	// only the framing stretch matters, so two bits suffice
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			n_tx_r <= 2'd0;
		end else if (TX_VALID && n_tx_r != 2'd3) begin
			n_tx_r <= n_tx_r + 2'd1;
		end
	end
	// ------------------------------
	// sequences and assertions
	// ------------------------------
	sequence s_access;
		PSEL && PENABLE && !PREADY;
	endsequence
	sequence s_unmapped;
		s_access ##0 (PADDR > `LBL_OFS_RX_ACC);
	endsequence
	a_ready_next: assert property (s_access |=> PREADY) else $error("no ready after access");
	a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
	a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE)) else $error("ready without access");
	a_unmapped_err: assert property (s_unmapped |=> PSLVERR) else $error("unmapped access not refused");
	a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
	a_tx_answer: assert property (TX_REQ |=> TX_VALID) else $error("char request unanswered");
	a_tx_cause: assert property (TX_VALID |-> $past(TX_REQ)) else $error("char without request");
	a_frame_idles: assert property (TX_VALID && n_tx_r != 2'd3 |-> TX_CHAR == `LBL_IDLE_CHAR)
		else $error("framing char not idle");
endmodule : lbl_engine_checker

// ### lbl_remote.sv
// model of the remote line terminal: paces char requests, logs them, sends chars
`timescale 1ns/1ns
`include "lbl_defs.svh"
module lbl_remote (
	input  wire logic       clk_sys,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_char,
	output logic            tx_req,
	output logic            rx_valid,
	output logic      [7:0] rx_char,
	output logic            rx_vpar_err
);
	logic       run = 1'b0;  // pacing starts once the engine is enabled
	logic       vpe = 1'b0;  // next char sent carries a vertical parity error
	logic [1:0] pace = 2'd0; // one request every four cycles stands in for the line rate
	int         idles = 0;   // idles since the last other char
	logic [7:0] got[$];      // non-idle chars heard, in order
	int         gap[$];      // idles that came before each of them
	initial begin
		tx_req = 1'b0;
		rx_valid = 1'b0;
		rx_char = 8'h00;
		rx_vpar_err = 1'b0;
	end
	// ------------------------------
	// transmit side: request and log
	// ------------------------------
	always @(posedge clk_sys) begin
		pace <= pace + 2'd1;
		tx_req <= run && pace == 2'd0;
		if (tx_valid === 1'b1 && tx_char == `LBL_IDLE_CHAR) begin
			idles = idles + 1;
		end else if (tx_valid === 1'b1) begin
			got.push_back(tx_char);
			gap.push_back(idles);
			idles = 0;
		end
	end
	// ------------------------------
	// receive side: one char per call
	// ------------------------------
	// the line shows the inverse afterwards so a stale char never passes for a new one
	task automatic send(input logic [7:0] c);
		@(posedge clk_sys);
		rx_valid <= 1'b1;
		rx_char <= c;
		rx_vpar_err <= vpe;
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		rx_char <= ~c;
		rx_vpar_err <= 1'b0;
	endtask : send
endmodule : lbl_remote

// ### lbl_engine_tb.sv
// self-checking testbench of the line block link engine
`timescale 1ns/1ns
`include "lbl_defs.svh"
module lbl_engine_tb;
	logic        CLK_SYS = 1'b0; // 125 MHz
	logic        SRST = 1'b1;    // five cycles at start
	logic        PSEL = 1'b0;    // apb master side
	logic        PENABLE = 1'b0;
	logic        PWRITE = 1'b0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	logic        RX_VALID;       // line side, from the remote model
	logic [7:0]  RX_CHAR;
	logic        RX_VPAR_ERR;
	logic        TX_REQ;
	logic        TX_VALID;
	logic [7:0]  TX_CHAR;
	logic [31:0] rdat;           // last read data
	logic        rerr;           // last error flag
	int          n_mismatch = 0;
	int          checked = 0;
	int          lastgap;        // idles before the last char taken
	int          n;
	always #4 CLK_SYS = ~CLK_SYS;
	lbl_engine lbl_engine_i (.CLK_SYS, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
		.PSLVERR, .RX_VALID, .RX_CHAR, .RX_VPAR_ERR, .TX_REQ, .TX_VALID, .TX_CHAR);
	lbl_remote lbl_remote_i (.clk_sys(CLK_SYS), .tx_valid(TX_VALID), .tx_char(TX_CHAR), .tx_req(TX_REQ),
		.rx_valid(RX_VALID), .rx_char(RX_CHAR), .rx_vpar_err(RX_VPAR_ERR));
	// ------------------------------
	// tasks
	// ------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		// no assumed latency: only the watchdog ends a hung access
		do begin
			@(posedge CLK_SYS);
		end while (PREADY !== 1'b1);
		rdat = PRDATA;
		rerr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic st(input logic [7:0] m, input logic [7:0] e);
		apb(1'b0, `LBL_OFS_STATUS, 32'h0);
		chk(rdat & {24'h0, m}, {24'h0, e});
	endtask : st
	// next non-idle char from the line, bounded wait
	task automatic getc(input logic [7:0] e);
		int w;
		w = 0;
		while (lbl_remote_i.got.size() == 0 && w < 3000) begin
			@(posedge CLK_SYS);
			w++;
		end
		if (lbl_remote_i.got.size() == 0) begin
			chk(32'hFFFF_FFFF, {24'h0, e});
		end else begin
			lastgap = lbl_remote_i.gap.pop_front();
			chk({24'h0, lbl_remote_i.got.pop_front()}, {24'h0, e});
		end
	endtask : getc
	function automatic logic [7:0] par(input logic [7:0] base);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 0; i < 80; i++) p = p ^ (base + 8'(i));
		return p;
	endfunction : par
	task automatic put_blk(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] base);
		for (int i = 0; i < 80; i++) apb(1'b1, `LBL_OFS_TX_DATA, {24'h0, base + 8'(i)});
		apb(1'b1, `LBL_OFS_TX_CTL, {15'h0, 1'b1, c2, c1});
	endtask : put_blk
	task automatic body(input logic [7:0] b, input logic [7:0] s, input logic [7:0] base);
		getc(b);
		getc(s);
		for (int i = 0; i < 80; i++) getc(base + 8'(i));
	endtask : body
	// a reply char mid-data and an idle before the end must not disturb the block
	// bad[0] spoils the parity char, bad[1] flags a vertical parity error on one data char
	task automatic rx_blk(input logic [7:0] b, s, base, endc, input logic [1:0] bad);
		lbl_remote_i.send(b);
		lbl_remote_i.send(s);
		for (int i = 0; i < 80; i++) begin
			if (i == 40) lbl_remote_i.send(`LBL_HOLD_ANSWER);
			lbl_remote_i.vpe = bad[1] && i == 10;
			lbl_remote_i.send(base + 8'(i));
		end
		lbl_remote_i.send(`LBL_IDLE_CHAR);
		lbl_remote_i.send(endc);
		lbl_remote_i.send(par(base) ^ {7'h0, bad[0]});
	endtask : rx_blk
	task automatic finish_test();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	// ------------------------------
	// tests
	// ------------------------------
	initial begin
		repeat (5) @(posedge CLK_SYS);
		SRST <= 1'b0;
		lbl_remote_i.send(`LBL_FAULT_ANSWER);
		st(8'hFF, 8'h10);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		$display("test reset done");
		apb(1'b1, `LBL_OFS_CTRL, 32'h1);
		lbl_remote_i.run <= 1'b1;
		n = 0;
		do begin
			apb(1'b0, `LBL_OFS_STATUS, 32'h0);
			n++;
		end while (rdat[0] !== 1'b1 && n < 100);
		chk(rdat & 32'h3, 32'h3);
		$display("test framing done");
		rx_blk(`LBL_MSG_BEGIN_LOW, `LBL_ROUTE_CHAR_ZERO, 8'h21, `LBL_SEG_END_CHAR, 2'b00);
		getc(`LBL_HOLD_ANSWER);
		st(8'h64, 8'h24);
		for (int i = 0; i < 80; i++) begin
			apb(1'b0, `LBL_OFS_RX_DATA, 32'h0);
			chk(rdat, {24'h0, 8'h21 + 8'(i)});
		end
		lbl_remote_i.send(`LBL_RESEND_POLL);
		getc(`LBL_HOLD_ANSWER);
		apb(1'b1, `LBL_OFS_RX_ACC, 32'h1);
		getc(`LBL_POS_ANSWER_ONE);
		rx_blk(`LBL_SEG_BEGIN_CHAR, `LBL_ROUTE_CHAR_ZERO, 8'h40, `LBL_MSG_END_CHAR, 2'b01);
		getc(`LBL_FAULT_ANSWER);
		st(8'h20, 8'h20);
		rx_blk(`LBL_SEG_BEGIN_CHAR, `LBL_ROUTE_CHAR_ZERO, 8'h40, `LBL_MSG_END_CHAR, 2'b10);
		getc(`LBL_FAULT_ANSWER);
		$display("test receive done");
		put_blk(8'h1C, 8'h00, 8'h31);
		body(`LBL_MSG_BEGIN_HIGH, `LBL_ROUTE_CHAR_ONE, 8'h31);
		getc(`LBL_SEG_END_CHAR);
		getc(par(8'h31));
		st(8'h18, 8'h08);
		lbl_remote_i.send(`LBL_POS_ANSWER_ONE);
		st(8'h1A, 8'h12);
		put_blk(8'h00, 8'h01, 8'h50);
		body(`LBL_SEG_BEGIN_CHAR, `LBL_IGNORE_CHAR, 8'h50);
		getc(`LBL_MSG_END_CHAR);
		getc(par(8'h50));
		lbl_remote_i.send(`LBL_HOLD_ANSWER);
		st(8'h18, 8'h00);
		lbl_remote_i.send(`LBL_FAULT_ANSWER);
		st(8'h18, 8'h00);
		put_blk(8'h04, 8'h00, 8'h80);
		body(`LBL_MSG_BEGIN_LOW, `LBL_ROUTE_CHAR_ZERO, 8'h80);
		getc(`LBL_RESEND_POLL);
		st(8'h08, 8'h08);
		lbl_remote_i.send(`LBL_POS_ANSWER_TWO);
		getc(`LBL_SEG_END_CHAR);
		chk({31'h0, lastgap >= 40 && lastgap <= 80}, 32'h1);
		getc(par(8'h80));
		lbl_remote_i.send(`LBL_FAULT_ANSWER);
		body(`LBL_MSG_BEGIN_LOW, `LBL_ROUTE_CHAR_ZERO, 8'h80);
		getc(`LBL_SEG_END_CHAR);
		getc(par(8'h80));
		apb(1'b1, `LBL_OFS_TX_CTL, 32'h00010001);
		getc(`LBL_REJECT_MESSAGE);
		$display("test transmit done");
		finish_test();
	end
	// watchdog: about fifty thousand cycles, far beyond the expected run
	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end
endmodule : lbl_engine_tb
bind lbl_engine lbl_engine_checker lbl_engine_checker_i (.CLK_SYS, .SRST, .PSEL, .PENABLE, .PADDR, .PREADY,
	.PSLVERR, .TX_REQ, .TX_VALID, .TX_CHAR);
